// ### design/ahbp_edge.sv
`timescale 1ns/1ps
module ahbp_edge (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // sampled level
  input  wire logic level_in,
  // edge pulses
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic prev;
  } ahbp_edge_st_t;
  ahbp_edge_st_t s_q;
  ahbp_edge_st_t s_d;
  always_comb begin
    s_d.prev = level_in;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '{prev: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end
  assign rise = level_in & ~s_q.prev;
  assign fall = ~level_in & s_q.prev;
endmodule : ahbp_edge

// ### design/ahbp_pkg.sv
// What this block does
// - width select high: upper data pins float, all traffic on low eight pins.
// - width select low: instructions and results use all sixteen pins.
// - drive data pins only while read strobe and chip select are both low.
// - accept write data only while write strobe and chip select are low.
// - chip select low halts internal clocking; conversion resumes when it rises.
// - latch enable high makes the bus address pass through as valid.
// - latch enable falling with chip select low captures the five address lines.
// - latch enable low: address and chip select changes are ignored.
// - reading interrupt status holds int_n high only while read strobe is low; the pending interrupt is not cleared.
// - transfer request drops once reads have emptied the result buffer.
package ahbp_pkg;
  localparam int        AHBP_AW           = 5;
  localparam int        AHBP_DW           = 16;
  localparam int        AHBP_BW           = 8;
  localparam logic [4:0] AHBP_ADDR_INTSTAT = 5'h0a;
  localparam logic [4:0] AHBP_ADDR_FIFO    = 5'h1e;
  localparam logic [4:0] AHBP_ADDR_RST     = 5'h00;
  localparam logic [15:0] AHBP_DATA_RST    = 16'h0000;
endpackage : ahbp_pkg

// ### design/ahbp_port.sv
`timescale 1ns/1ps
module ahbp_port
  import ahbp_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // host strobes
  input  wire logic               cs_n,
  input  wire logic               rd_n,
  input  wire logic               wr_n,
  input  wire logic               ale,
  input  wire logic               bus_width_select,
  input  wire logic [AHBP_AW-1:0] host_address_lines,
  // data pins
  input  wire logic [AHBP_DW-1:0] host_data_pins_i,
  output logic      [AHBP_DW-1:0] host_data_pins_o,
  output logic      [AHBP_DW-1:0] host_data_pins_oe,
  // core side
  input  wire logic [AHBP_DW-1:0] core_rdata,
  input  wire logic               core_int_pend,
  input  wire logic               core_fifo_empty,
  input  wire logic               core_dma_level,
  output logic                    core_clk_run,
  output logic      [AHBP_AW-1:0] core_addr,
  output logic                    core_wr_stb,
  output logic      [AHBP_DW-1:0] core_wdata,
  output logic                    core_rd_stb,
  // status pins
  output logic                    int_n,
  output logic                    transfer_request_out
);
  typedef struct packed {
    logic [AHBP_AW-1:0] addr;
    logic               cs_lat;
    logic [AHBP_DW-1:0] dout;
    logic [AHBP_DW-1:0] oe;
    logic               run;
    logic               wr_stb;
    logic [AHBP_DW-1:0] wdata;
    logic               rd_stb;
    logic               int_n;
    logic               dreq;
  } ahbp_st_t;

  ahbp_st_t s_q;
  ahbp_st_t s_d;
  logic     ale_rise;
  logic     ale_fall;
  logic     wr_rise;
  logic     rd_fall;

  ahbp_edge u_ale_edge (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .level_in (ale),
    .rise     (ale_rise),
    .fall     (ale_fall)
  );
  ahbp_edge u_wr_edge (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .level_in (wr_n),
    .rise     (wr_rise),
    .fall     ()
  );
  ahbp_edge u_rd_edge (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .level_in (rd_n),
    .rise     (),
    .fall     (rd_fall)
  );

  // effective address: transparent while latch enable high
  function automatic logic [AHBP_AW-1:0] eff_addr(
    input logic al, input logic [AHBP_AW-1:0] a, input logic [AHBP_AW-1:0] l);
    eff_addr = al ? a : l;
  endfunction : eff_addr

  // lanes enabled by the width select
  function automatic logic [AHBP_DW-1:0] lane_mask(input logic bw);
    lane_mask = bw ? {{(AHBP_DW-AHBP_BW){1'b0}}, {AHBP_BW{1'b1}}}
                   : {AHBP_DW{1'b1}};
  endfunction : lane_mask

  logic               cs_eff;
  logic [AHBP_AW-1:0] a_eff;
  logic               rd_ok;
  logic               wr_ok;

  always_comb begin
    s_d = s_q;
    cs_eff = ale ? cs_n : s_q.cs_lat;
    a_eff = eff_addr(ale, host_address_lines, s_q.addr);
    rd_ok = ~rd_n & ~cs_eff;
    wr_ok = ~wr_n & ~cs_eff;
    if (ale) begin
      s_d.addr = host_address_lines;
      s_d.cs_lat = cs_n;
    end
    if (ale_fall && !cs_n) begin
      s_d.addr = host_address_lines;
      s_d.cs_lat = cs_n;
    end
    s_d.run = cs_n;
    s_d.oe = rd_ok ? lane_mask(bus_width_select) : '0;
    s_d.dout = rd_ok ? (core_rdata & lane_mask(bus_width_select))
                     : AHBP_DATA_RST;
    s_d.wr_stb = wr_rise & ~cs_eff;
    if (wr_ok) begin
      s_d.wdata = host_data_pins_i & lane_mask(bus_width_select);
    end
    s_d.rd_stb = rd_fall & ~cs_eff;
    s_d.int_n = ~core_int_pend;
    if (rd_ok && a_eff == AHBP_ADDR_INTSTAT) begin
      s_d.int_n = 1'b1;
    end
    s_d.dreq = core_dma_level & ~core_fifo_empty;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '{addr: AHBP_ADDR_RST, cs_lat: 1'b1, dout: AHBP_DATA_RST,
               oe: AHBP_DATA_RST, run: 1'b1, wr_stb: 1'b0,
               wdata: AHBP_DATA_RST, rd_stb: 1'b0, int_n: 1'b1,
               dreq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign host_data_pins_o     = s_q.dout;
  assign host_data_pins_oe    = s_q.oe;
  assign core_clk_run         = s_q.run;
  assign core_addr            = s_q.addr;
  assign core_wr_stb          = s_q.wr_stb;
  assign core_wdata           = s_q.wdata;
  assign core_rd_stb          = s_q.rd_stb;
  assign int_n                = s_q.int_n;
  assign transfer_request_out = s_q.dreq;

  chk_upper_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(bus_width_select) |-> host_data_pins_oe[15:8] == 8'h00)
    else $error("upper lanes driven in byte mode");
  chk_wide_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!bus_width_select && !rd_n && !cs_n && ale)
      |-> host_data_pins_oe == 16'hffff)
    else $error("wide read not driving all lanes");
  chk_read_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!rd_n && !cs_n && ale) |-> host_data_pins_oe[7:0] == 8'hff)
    else $error("read not driving low lanes");
  chk_float_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rd_n) |-> host_data_pins_oe == 16'h0000)
    else $error("pins driven without read");
  chk_write_take: assert property (@(posedge sys_clk) disable iff (!rst_n)
    core_wr_stb |-> $past(wr_n, 1) && !$past(wr_n, 2))
    else $error("write strobe without write");
  chk_clock_halt: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!cs_n) |-> !core_clk_run)
    else $error("clock runs during select");
  chk_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!ale) && !$past(ale, 2) |-> $stable(core_addr))
    else $error("latched address changed");
  chk_addr_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(ale) |-> core_addr == $past(host_address_lines))
    else $error("address not captured");
  chk_int_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!rd_n && !cs_n && ale && host_address_lines == AHBP_ADDR_INTSTAT)
      |-> int_n)
    else $error("interrupt not cleared by status read");
  chk_dreq_empty: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(core_fifo_empty) |-> !transfer_request_out)
    else $error("request high with empty buffer");
  cov_read: cover property (@(posedge sys_clk) !rd_n && !cs_n ##1 rd_n);
  cov_write: cover property (@(posedge sys_clk) core_wr_stb);
  cov_mux: cover property (@(posedge sys_clk) ale ##1 !ale && !cs_n);
endmodule : ahbp_port

// ### tb/ahbp_host.sv
`timescale 1ns/1ps
module ahbp_host (
  // clock
  input  wire logic        sys_clk,
  // host bus
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             ale,
  output logic [4:0]       addr,
  output logic [15:0]      dout
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ale = 1'b1;
    addr = 5'h00;
    dout = 16'h0000;
  end
  // select only for the access; ale stays high on a split bus
  task automatic begin_acc(input logic w, mux, input logic [4:0] a,
                           input logic [15:0] d);
    @(negedge sys_clk);
    ale = 1'b1;
    addr = a;
    cs_n = 1'b0;
    dout = w ? d : ~dout;
    if (mux) begin
      @(negedge sys_clk);
      ale = 1'b0;
    end
    @(negedge sys_clk);
    // address holds past the latch edge, then goes stale on purpose
    if (mux) addr = ~a;
    if (w) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : begin_acc
  task automatic end_acc();
    rd_n = 1'b1;
    wr_n = 1'b1;
    @(negedge sys_clk);
    ale = 1'b1;
    cs_n = 1'b1;
    dout = ~dout;
    repeat (3) @(negedge sys_clk);
  endtask : end_acc
endmodule : ahbp_host

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import ahbp_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, bw = 1'b0, ip = 1'b0, fe = 1'b1;
  logic dl = 1'b0, w, mux, clk_run, wstb, rstb, int_n, req;
  logic cs_n, rd_n, wr_n, ale;
  logic [4:0] a, ha, caddr;
  logic [15:0] d, hd, rdat = 16'h0000, po, poe, wdat, lanes;
  wire [15:0] pins = (poe & po) | (~poe & hd);
  integer seed = 32'h41da, n_errors = 0, n_compared = 0;
  integer n_wstb = 0, n_rstb = 0, w0, r0;
  always #12.5 sys_clk = ~sys_clk;
  // count one-cycle core strobes
  always @(posedge sys_clk) begin
    if (wstb === 1'b1) n_wstb++;
    if (rstb === 1'b1) n_rstb++;
  end
  ahbp_host host (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .ale(ale), .addr(ha), .dout(hd));
  ahbp_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .bus_width_select(bw),
    .host_address_lines(ha), .host_data_pins_i(pins),
    .host_data_pins_o(po), .host_data_pins_oe(poe), .core_rdata(rdat),
    .core_int_pend(ip), .core_fifo_empty(fe), .core_dma_level(dl),
    .core_clk_run(clk_run), .core_addr(caddr), .core_wr_stb(wstb),
    .core_wdata(wdat), .core_rd_stb(rstb), .int_n(int_n),
    .transfer_request_out(req));
  task automatic check(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : check
  function automatic logic [15:0] lane_mask(input logic b);
    return b ? 16'h00ff : 16'hffff;
  endfunction : lane_mask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    check("int_n", 16'h1, int_n);
    for (int i = 0; i < 24; i++) begin
      w = (i < 4) ? 1'b0 : $random(seed);
      mux = i[0];
      bw = i[1];
      a = (i < 4) ? AHBP_ADDR_INTSTAT : $random(seed);
      d = $random(seed);
      rdat = $random(seed);
      ip = (i < 4) ? 1'b1 : $random(seed);
      {fe, dl} = $random(seed);
      lanes = lane_mask(bw);
      w0 = n_wstb;
      r0 = n_rstb;
      host.begin_acc(w, mux, a, d);
      check("core_addr", a, caddr);
      check("core_clk_run", 16'h0, clk_run);
      check("oe", w ? 16'h0 : lanes, poe);
      if (!w) check("read data", rdat & lanes, po & lanes);
      if (!w && a == AHBP_ADDR_INTSTAT) check("int_n", 16'h1, int_n);
      host.end_acc();
      if (w) check("core_wdata", d & lanes, wdat);
      check("oe idle", 16'h0, poe);
      check("core_clk_run", 16'h1, clk_run);
      check("int_n", {15'h0000, ~ip}, int_n);
      check("write strobes", {15'h0000, w}, n_wstb - w0);
      check("read strobes", {15'h0000, ~w}, n_rstb - r0);
      check("request", dl & ~fe, req);
      $display("test %0d done", i);
    end
    complete_run();
  end
endmodule : tb
